// ---- pll_status_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the status bank
`ifndef PLL_STATUS_CFG_SVH
`define PLL_STATUS_CFG_SVH

// Register indices, byte address is four times the index
`define PS_IDX_W         10
`define PS_IDX_THRESH    10'h01a
`define PS_IDX_STATUS    10'h01f
`define PS_IDX_EVENT     10'h020
`define PS_IDX_MASK      10'h021

// Status register field positions
`define PS_BIT_LOCK      0
`define PS_BIT_PRI       1
`define PS_BIT_SEC       2
`define PS_BIT_OSC       3
`define PS_BIT_REFSEL    4
`define PS_BIT_HOLD      5
`define PS_BIT_CAL       6

// Threshold select field of the threshold control register
`define PS_BIT_THRESH    6

// Widths of the status and event fields and of the monitor inputs
`define PS_STAT_W        7
`define PS_MON_W         8

// Reset values
`define PS_THRESH_RST    1'b0
`define PS_EVENT_RST     7'h00
`define PS_MASK_RST      7'h00
`define PS_RDATA_RST     32'h0000_0000

// Synchroniser depth in clock cycles
`define PS_SYNC_STAGES   2

`endif

// ---- pll_status_pkg.sv ----
// Types shared by the status bank modules
package pll_status_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_THRESH,
        SEL_STATUS,
        SEL_EVENT,
        SEL_MASK
    } reg_sel_t;

endpackage

// ---- pll_status_sync.sv ----
// Multi-bit two-stage level synchroniser for monitor inputs
`timescale 1ns/1ps
`include "pll_status_cfg.svh"

module pll_status_sync #(
    parameter int WIDTH = `PS_MON_W
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // pll_status_sync

// ---- pll_status_readback.sv ----
// Loop status readback bank with AHB-Lite slave and change interrupts
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "pll_status_cfg.svh"

module pll_status_readback (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Asynchronous monitor indications
    input  wire logic        holdover_in,
    input  wire logic        secondary_ref_in_use_flag,
    input  wire logic        diff_ref_mode_in,
    input  wire logic        osc_above_in,
    input  wire logic        secondary_reference_input_above,
    input  wire logic        primary_reference_input_above,
    input  wire logic        lock_detect_in,
    input  wire logic        cal_done_in,
    // Threshold select for the reference monitors
    output logic             ref_threshold_sel,
    // Interrupt
    output logic             irq
);

    // Address phase decode to a register select
    function automatic pll_status_pkg::reg_sel_t map_sel(
        input logic [31:0] addr
    );
        logic [`PS_IDX_W-1:0] idx;
        idx = addr[`PS_IDX_W+1:2];
        map_sel = pll_status_pkg::SEL_NONE;
        if (addr[31:`PS_IDX_W+2] == '0 && addr[1:0] == 2'h0) begin
            unique case (idx)
                `PS_IDX_THRESH: map_sel = pll_status_pkg::SEL_THRESH;
                `PS_IDX_STATUS: map_sel = pll_status_pkg::SEL_STATUS;
                `PS_IDX_EVENT:  map_sel = pll_status_pkg::SEL_EVENT;
                `PS_IDX_MASK:   map_sel = pll_status_pkg::SEL_MASK;
                default:        map_sel = pll_status_pkg::SEL_NONE;
            endcase
        end
    endfunction

    logic [`PS_MON_W-1:0]      mon_raw;
    logic [`PS_MON_W-1:0]      mon_s;
    logic [7:0]                status_w;
    logic                      refsel_w;
    logic                      acc_w;
    logic                      rd_acc_w;
    logic                      wr_acc_w;
    pll_status_pkg::reg_sel_t  addr_sel_w;
    pll_status_pkg::reg_sel_t  wr_sel_q;
    logic                      wr_pend_q;
    logic                      wr_thresh_w;
    logic                      wr_event_w;
    logic                      wr_mask_w;
    logic [31:0]               rdata_d;
    logic [31:0]               rdata_q;
    logic                      thresh_d;
    logic                      thresh_q;
    logic [`PS_STAT_W-1:0]     mask_d;
    logic [`PS_STAT_W-1:0]     mask_q;
    logic [`PS_STAT_W-1:0]     prev_q;
    logic [`PS_STAT_W-1:0]     change_w;
    logic [`PS_STAT_W-1:0]     clear_w;
    logic [`PS_STAT_W-1:0]     event_d;
    logic [`PS_STAT_W-1:0]     event_q;

    // Monitor inputs gathered for the synchroniser
    assign mon_raw = {diff_ref_mode_in,
                      cal_done_in,
                      holdover_in,
                      secondary_ref_in_use_flag,
                      osc_above_in,
                      secondary_reference_input_above,
                      primary_reference_input_above,
                      lock_detect_in};

    pll_status_sync #(
        .WIDTH    (`PS_MON_W)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (mon_raw),
        .sync_out (mon_s)
    );

    assign refsel_w = mon_s[4] & ~mon_s[7];

    // Live status word, bit 7 reserved as zero
    // lock detect bit
    assign status_w[`PS_BIT_LOCK]   = mon_s[0];
    assign status_w[`PS_BIT_PRI]    = mon_s[1];
    assign status_w[`PS_BIT_SEC]    = mon_s[2];
    assign status_w[`PS_BIT_OSC]    = mon_s[3];
    assign status_w[`PS_BIT_REFSEL] = refsel_w;
    assign status_w[`PS_BIT_HOLD]   = mon_s[5];
    assign status_w[`PS_BIT_CAL]    = mon_s[6];
    assign status_w[7]              = 1'b0;

    // Bus transfer qualification
    assign acc_w      = hsel & hready & htrans[1];
    assign rd_acc_w   = acc_w & ~hwrite;
    assign wr_acc_w   = acc_w & hwrite;
    assign addr_sel_w = map_sel(haddr);

    // Write data phase strobes; the status select has no strobe at all
    // status ignores writes
    assign wr_thresh_w = wr_pend_q & (wr_sel_q == pll_status_pkg::SEL_THRESH);
    assign wr_event_w  = wr_pend_q & (wr_sel_q == pll_status_pkg::SEL_EVENT);
    assign wr_mask_w   = wr_pend_q & (wr_sel_q == pll_status_pkg::SEL_MASK);

    // Write address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_sel_q  <= pll_status_pkg::SEL_NONE;
        end else begin
            wr_pend_q <= wr_acc_w;
            wr_sel_q  <= addr_sel_w;
        end
    end

    // Read mux, unmapped reads return zero
    // read shows live status
    assign rdata_d =
        !rd_acc_w ? `PS_RDATA_RST :
        (addr_sel_w == pll_status_pkg::SEL_STATUS) ? {24'h0, status_w} :
        (addr_sel_w == pll_status_pkg::SEL_THRESH) ?
            (32'h0 | ({31'h0, thresh_q} << `PS_BIT_THRESH)) :
        (addr_sel_w == pll_status_pkg::SEL_EVENT)  ? {25'h0, event_q} :
        (addr_sel_w == pll_status_pkg::SEL_MASK)   ? {25'h0, mask_q} :
        `PS_RDATA_RST;

    // Read data register for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= `PS_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Threshold select and mask next values
    // threshold select register
    assign thresh_d = wr_thresh_w ? hwdata[`PS_BIT_THRESH] : thresh_q;
    assign mask_d   = wr_mask_w ? hwdata[`PS_STAT_W-1:0] : mask_q;

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thresh_q <= `PS_THRESH_RST;
            mask_q   <= `PS_MASK_RST;
        end else begin
            thresh_q <= thresh_d;
            mask_q   <= mask_d;
        end
    end

    // Change detect, write one clears, a new change beats the clear
    assign change_w = status_w[`PS_STAT_W-1:0] ^ prev_q;
    assign clear_w  = wr_event_w ? hwdata[`PS_STAT_W-1:0] : `PS_EVENT_RST;
    assign event_d  = (event_q & ~clear_w) | change_w;

    // Sticky change events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q  <= '0;
            event_q <= `PS_EVENT_RST;
        end else begin
            prev_q  <= status_w[`PS_STAT_W-1:0];
            event_q <= event_d;
        end
    end

    // Outputs
    assign hreadyout         = 1'b1;    // Zero wait states
    assign hresp             = 1'b0;    // Always OKAY
    assign hrdata            = rdata_q;
    assign ref_threshold_sel = thresh_q;
    assign irq               = |(event_q & mask_q);

    // Cycles since reset, lets past samples settle
    logic [1:0] up_q;
    logic       up_ok;
    logic       rd_stat_w;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end

    assign up_ok     = (up_q == 2'h3);
    assign rd_stat_w = rd_acc_w & (addr_sel_w == pll_status_pkg::SEL_STATUS);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Status read against the pins three edges back
    a_holdover_read: assert property (
        rd_stat_w && up_ok |=>
            hrdata[`PS_BIT_HOLD] == $past(holdover_in, 3))
        else $error("holdover bit does not follow the holdover state");

    a_refsel_read: assert property (
        rd_stat_w && up_ok |=> hrdata[`PS_BIT_REFSEL] ==
            $past(secondary_ref_in_use_flag & ~diff_ref_mode_in, 3))
        else $error("reference select bit is wrong");

    a_osc_read: assert property (
        rd_stat_w && up_ok |=>
            hrdata[`PS_BIT_OSC] == $past(osc_above_in, 3))
        else $error("oscillator threshold bit is wrong");

    a_sec_read: assert property (
        rd_stat_w && up_ok |=> hrdata[`PS_BIT_SEC] ==
            $past(secondary_reference_input_above, 3))
        else $error("secondary threshold bit is wrong");

    a_pri_read: assert property (
        rd_stat_w && up_ok |=> hrdata[`PS_BIT_PRI] ==
            $past(primary_reference_input_above, 3))
        else $error("primary threshold bit is wrong");

    a_lock_read: assert property (
        rd_stat_w && up_ok |=>
            hrdata[`PS_BIT_LOCK] == $past(lock_detect_in, 3))
        else $error("lock bit is wrong");

    a_status_ro: assert property (
        wr_acc_w && addr_sel_w == pll_status_pkg::SEL_STATUS |=>
            ##1 $stable(thresh_q) && $stable(mask_q))
        else $error("status write altered another register");

    a_holdover_pos: assert property (
        up_ok |-> status_w[`PS_BIT_HOLD] == $past(holdover_in, 2))
        else $error("holdover not at bit five");

    a_cal_read: assert property (
        rd_stat_w && up_ok |=> hrdata[`PS_BIT_CAL] ==
            $past(cal_done_in, 3) && hrdata[31:7] == 25'h0)
        else $error("calibration bit or reserved bits are wrong");

    a_sync_delay: assert property (
        up_ok && $rose(lock_detect_in) |->
            !status_w[`PS_BIT_LOCK] ##1 !status_w[`PS_BIT_LOCK])
        else $error("lock input reached status before two flops");

    a_thresh_write: assert property (
        wr_acc_w && addr_sel_w == pll_status_pkg::SEL_THRESH |=>
            ##1 ref_threshold_sel == $past(hwdata[`PS_BIT_THRESH]))
        else $error("threshold select did not take the write");

    a_event_set: assert property (
        up_ok && $changed(status_w[`PS_BIT_LOCK]) |=> event_q[`PS_BIT_LOCK])
        else $error("lock change did not set its event");

    a_irq_mask: assert property (
        mask_q == `PS_MASK_RST |-> !irq)
        else $error("interrupt raised with all events masked");

    c_read_locked: cover property (
        rd_stat_w && status_w[`PS_BIT_LOCK] ##1 hrdata[`PS_BIT_LOCK]);

    c_irq_rise: cover property ($rose(irq));

    c_event_clear: cover property (
        wr_event_w && hwdata[`PS_BIT_LOCK] ##1 !event_q[`PS_BIT_LOCK]);

endmodule // pll_status_readback

// ---- tb.sv ----
// Self-checking testbench for the loop status readback bank
`timescale 1ns/1ps
`include "pll_status_cfg.svh"

module tb;
    localparam logic [31:0] A_STAT = {20'h0, `PS_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_THR  = {20'h0, `PS_IDX_THRESH, 2'b00};
    localparam logic [31:0] A_EVT  = {20'h0, `PS_IDX_EVENT, 2'b00};
    localparam logic [31:0] A_MSK  = {20'h0, `PS_IDX_MASK, 2'b00};

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  pins;
    logic        ref_threshold_sel;
    logic        irq;
    int          failures;
    int          checks_done;
    int          cycles = 0;

    // One slave, so its ready is the bus ready
    assign hready = hreadyout;

    pll_status_readback pll_status_readback_inst (
        .hclk                            (hclk),
        .hresetn                         (hresetn),
        .hsel                            (hsel),
        .haddr                           (haddr),
        .htrans                          (htrans),
        .hwrite                          (hwrite),
        .hsize                           (hsize),
        .hwdata                          (hwdata),
        .hready                          (hready),
        .hreadyout                       (hreadyout),
        .hresp                           (hresp),
        .hrdata                          (hrdata),
        .holdover_in                     (pins[5]),
        .secondary_ref_in_use_flag       (pins[4]),
        .diff_ref_mode_in                (pins[7]),
        .osc_above_in                    (pins[3]),
        .secondary_reference_input_above (pins[2]),
        .primary_reference_input_above   (pins[1]),
        .lock_detect_in                  (pins[0]),
        .cal_done_in                     (pins[6]),
        .ref_threshold_sel               (ref_threshold_sel),
        .irq                             (irq)
    );

    // Clock generation, 40 ns period
    always #20 hclk = ~hclk;

    // Cycle ceiling against hangs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // Compare seen against expected value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single AHB-Lite word transfer, waits on ready
    task automatic xfer(input logic [31:0] a, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(a, 1'b0, 32'h0000_0000, d);
        check(d, exp);
    endtask

    // Drive monitor pins and let the synchroniser settle
    task automatic set_pins(input logic [7:0] p);
        @(posedge hclk);
        pins <= p;
        repeat (4) @(posedge hclk);
    endtask

    task automatic t_reset();
        check({31'h0, irq}, 32'h0000_0000);
        check({31'h0, ref_threshold_sel}, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0000_0000);
        check({31'h0, hreadyout}, 32'h0000_0001);
        // status reads zero out of reset
        rd_check(A_STAT, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_bits();
        for (int b = 0; b < `PS_STAT_W; b++) begin
            set_pins(8'h01 << b);
            rd_check(A_STAT, 32'h0000_0001 << b);
        end
        set_pins(8'h7f);
        rd_check(A_STAT, 32'h0000_007f);
        $display("test status bits done");
    endtask

    task automatic t_diff_ro();
        set_pins(8'h90);
        rd_check(A_STAT, 32'h0000_0000);
        set_pins(8'h30);
        wr(A_STAT, 32'hffff_ffff);
        rd_check(A_STAT, 32'h0000_0030);
        wr(A_STAT, 32'h0000_0000);
        rd_check(A_STAT, 32'h0000_0030);
        $display("test diff mode and read only done");
    endtask

    task automatic t_thresh();
        wr(A_THR, 32'hffff_ffff);
        check({31'h0, ref_threshold_sel}, 32'h0000_0001);
        rd_check(A_THR, 32'h0000_0001 << `PS_BIT_THRESH);
        wr(A_THR, 32'h0000_0000);
        check({31'h0, ref_threshold_sel}, 32'h0000_0000);
        rd_check(32'h0000_03fc, 32'h0000_0000);
        rd_check(32'h0001_007c, 32'h0000_0000);
        $display("test threshold done");
    endtask

    task automatic t_irq();
        set_pins(8'h00);
        wr(A_EVT, 32'h0000_007f);
        rd_check(A_EVT, 32'h0000_0000);
        wr(A_MSK, 32'h0000_0001);
        rd_check(A_MSK, 32'h0000_0001);
        set_pins(8'h08);
        check({31'h0, irq}, 32'h0000_0000);
        rd_check(A_EVT, 32'h0000_0008);
        set_pins(8'h09);
        check({31'h0, irq}, 32'h0000_0001);
        wr(A_MSK, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        wr(A_MSK, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        wr(A_EVT, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        rd_check(A_EVT, 32'h0000_0008);
        $display("test interrupt done");
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0000_0000;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        hwdata <= 32'h0000_0000;
        pins <= 8'h00;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_bits();
        t_diff_ro();
        t_thresh();
        t_irq();
        wrap_up();
    end
endmodule // tb
